// ### logic/snx_consts.svh
// constants of the serial nonvolatile extended command block
`ifndef SNX_CONSTS_SVH
`define SNX_CONSTS_SVH

// command codes
`define SNX_OP_FAST_READ   8'h0b
`define SNX_OP_IDENT       8'h9f
`define SNX_OP_UNIQUE      8'h4c
`define SNX_OP_SN_WRITE    8'hc2
`define SNX_OP_SN_READ     8'hc3
`define SNX_OP_SEC_WRITE   8'h42
`define SNX_OP_SEC_READ    8'h4b
`define SNX_OP_FSEC_READ   8'h49
`define SNX_OP_DEEP_SLEEP  8'hba

// bit-count end points within a phase
`define SNX_BYTE_LAST      7'h07
`define SNX_ADDR_LAST      7'h17
`define SNX_ID_LAST        7'h1f
`define SNX_CODE_LAST      7'h3f

// special sector geometry
`define SNX_SEC_TOP        8'hff
`define SNX_SEC_BYTES      256

// default array address width (256 k bytes)
`define SNX_ARRAY_ADDR_W   18

// timing
`define SNX_WAKE_RECOVERY_NS 10000
`define SNX_SYS_PERIOD_NS    10

`endif

// ### logic/snx_pkg.sv
// types of the serial nonvolatile extended command block
package snx_pkg;

	// link-side phase of a frame
	typedef enum logic [2:0] {
		SNX_ST_CMD    = 3'b000,
		SNX_ST_ADDR   = 3'b001,
		SNX_ST_DUMMY  = 3'b010,
		SNX_ST_READ   = 3'b011,
		SNX_ST_SN_WR  = 3'b100,
		SNX_ST_SEC_WR = 3'b101,
		SNX_ST_IGNORE = 3'b110
	} snx_lstate_t;

	// decoded command kind
	typedef enum logic [2:0] {
		SNX_K_FAST    = 3'b000,
		SNX_K_IDENT   = 3'b001,
		SNX_K_UNIQUE  = 3'b010,
		SNX_K_SN_RD   = 3'b011,
		SNX_K_SN_WR   = 3'b100,
		SNX_K_SEC_WR  = 3'b101,
		SNX_K_SEC_RD  = 3'b110,
		SNX_K_FSEC_RD = 3'b111
	} snx_kind_t;

	// system-side power state
	typedef enum logic [1:0] {
		SNX_SY_RUN   = 2'b00,
		SNX_SY_SLEEP = 2'b01,
		SNX_SY_WAKE  = 2'b10
	} snx_sstate_t;

endpackage

// ### logic/snx_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps

module snx_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,   // destination clock
	input  wire logic             i_rst_b, // async reset, active low
	input  wire logic [WIDTH-1:0] i_d,     // foreign level
	output logic      [WIDTH-1:0] o_q      // synchronised level
);

	logic [WIDTH-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stage1 <= '0;
			o_q    <= '0;
		end else begin
			stage1 <= i_d;
			o_q    <= stage1;
		end
	end

endmodule // snx_sync

// ### logic/snx_top.sv
// serial nonvolatile memory extended command logic
//
// Behaviour
// - fast read: command, 24-bit address, 8 dummy
// - reads shift out on falling edge, ignore input
// - fast read streams bytes, address wraps around
// - identity: maker, continuation, two product bytes
// - hold last identity bit until deselect
// - unique code: 64 fixed bits, input ignored
// - serial number written once, then refused
// - serial read gives 64 bits, zero if unwritten
// - sector write stores each complete byte
// - sector write increments, no wrap, discards overflow
// - sector read, no dummy, increments, no wrap
// - fast sector read adds 8 dummy bits
// - deep sleep entered at select rise
// - clock edge after sleep command cancels it
// - asleep: ignore clock and input, output floats
// - select fall wakes within 10 microseconds
// - protect bits choose shielded array range
// - latch, lock bit and guard pin gate writes
// - decode the nine extended command codes
// - latch cleared on wake, kept after writes
`timescale 1ns/1ps
`include "snx_consts.svh"

module snx_top
	import snx_pkg::*;
#(
	parameter int          ARRAY_ADDR_W = `SNX_ARRAY_ADDR_W,
	parameter logic [7:0]  MAKER_CODE   = 8'ha5,                 // arbitrary value
	parameter logic [7:0]  CONT_CODE    = 8'h7e,                 // arbitrary value
	parameter logic [15:0] PRODUCT_CODE = 16'h1234,              // arbitrary value
	parameter logic [63:0] UNIQUE_CODE  = 64'h0123_4567_89ab_cdef // arbitrary value
) (
	input  wire logic                    I_SYS_CLK,     // system clock, 100 MHz
	input  wire logic                    I_RST_B,       // async reset, active low
	input  wire logic                    I_SCK,         // serial clock from host
	input  wire logic                    I_CS_B,        // chip select, active low
	input  wire logic                    I_SI,          // serial data in
	input  wire logic                    I_WP_B,        // write guard pin, active low
	output logic                         O_SO,          // serial data out
	output logic                         O_SO_OE,       // serial out drive enable
	output logic [ARRAY_ADDR_W-1:0]      O_ARR_ADDR,    // array read address
	output logic                         O_ARR_RD,      // array read in progress
	input  wire logic [7:0]              I_ARR_RDATA,   // array byte at O_ARR_ADDR
	input  wire logic                    I_SET_LATCH,   // set write latch, pulse
	input  wire logic                    I_CLEAR_LATCH, // clear write latch, pulse
	input  wire logic                    I_PROTECT_SIZE_LO, // block protect low bit
	input  wire logic                    I_PROTECT_SIZE_HI, // block protect high bit
	input  wire logic                    I_STATUS_LOCK_ENABLE, // status lock bit
	input  wire logic [ARRAY_ADDR_W-1:0] I_CHK_ADDR,    // array write address to check
	output logic                         O_WRITE_LATCH, // write latch state
	output logic                         O_STATUS_WR_OK, // status write allowed
	output logic                         O_ARRAY_WR_OK, // array write at I_CHK_ADDR allowed
	output logic                         O_DEEP_SLEEP   // sleeping or waking
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks and timing

	localparam int WAKE_CYCLES = `SNX_WAKE_RECOVERY_NS / `SNX_SYS_PERIOD_NS;

	if (ARRAY_ADDR_W < 8 || ARRAY_ADDR_W > 24) begin : g_bad_width
		$error("array address width must lie between 8 and 24");
	end
	if (WAKE_CYCLES < 4 || WAKE_CYCLES > 1024) begin : g_bad_wake
		$error("wake recovery count does not fit the timer");
	end

	////////////////////////////////////////////////////////////////////////////
	// state types

	typedef struct packed {
		snx_lstate_t st;
		snx_kind_t   kind;
		logic [6:0]  cnt;
		logic [7:0]  sh;
		logic [23:0] addr;
		logic [63:0] tx;
		logic        over;
		logic        arr_rd;
	} snx_link_t;

	typedef struct packed {
		logic [`SNX_SEC_BYTES-1:0][7:0] sector;
		logic [63:0]                    serial;
		logic                           sn_locked;
	} snx_store_t;

	typedef struct packed {
		snx_sstate_t st;
		logic [9:0]  timer;
		logic        asleep;
		logic        latch;
		logic        cs_prev;
		logic        status_ok;
		logic        array_ok;
	} snx_sys_t;

	snx_link_t  lr, next_lr;
	snx_store_t mem, next_mem;
	snx_sys_t   sr, next_sr;

	logic       armed;
	logic       next_armed;
	logic       latch_s;
	logic       sel_s;
	logic       wp_s;
	logic       armed_s;
	logic       so_q;
	logic       so_oe_q;
	logic       wr_sec;
	logic       wr_sn;
	logic       link_rst_b;
	logic       arm_rst_b;
	logic [7:0] wr_idx;
	logic [7:0] wr_byte;

	// frame logic is held in reset while deselected or asleep
	assign link_rst_b = I_RST_B & ~I_CS_B & ~sr.asleep;
	assign arm_rst_b  = I_RST_B & ~sr.asleep;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// sector byte for a read; past the top the stream gives zeros
	function automatic logic [7:0] sec_byte(input snx_store_t m, input logic [7:0] idx,
	                                        input logic over);
		sec_byte = over ? 8'h00 : m.sector[idx];
	endfunction

	// block protect decode: upper quarter, upper half or all
	function automatic logic prot_hit(input logic hi, input logic lo,
	                                  input logic [ARRAY_ADDR_W-1:0] a);
		case ({hi, lo})
			2'b01:   prot_hit = &a[ARRAY_ADDR_W-1 -: 2];
			2'b10:   prot_hit = a[ARRAY_ADDR_W-1];
			2'b11:   prot_hit = 1'b1;
			default: prot_hit = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// crossings

	// write latch into the serial clock domain; settles during the command byte
	snx_sync #(.WIDTH(1)) u_sync_link (
		.i_clk   (I_SCK),
		.i_rst_b (link_rst_b),
		.i_d     (sr.latch),
		.o_q     (latch_s)
	);

	// select (active high), guard pin and sleep arm into the system domain;
	// select resets to its idle level so no false edge follows reset
	snx_sync #(.WIDTH(3)) u_sync_sys (
		.i_clk   (I_SYS_CLK),
		.i_rst_b (I_RST_B),
		.i_d     ({~I_CS_B, I_WP_B, armed}),
		.o_q     ({sel_s, wp_s, armed_s})
	);

	////////////////////////////////////////////////////////////////////////////
	// link frame logic, rising serial clock

	always_comb begin
		next_lr    = lr;
		next_armed = 1'b0;
		wr_sec     = 1'b0;
		wr_sn      = 1'b0;
		wr_idx     = lr.addr[7:0];
		wr_byte    = {lr.sh[6:0], I_SI};
		case (lr.st)
			SNX_ST_CMD: begin
				next_lr.sh  = {lr.sh[6:0], I_SI};
				next_lr.cnt = lr.cnt + 7'h01;
				if (lr.cnt == `SNX_BYTE_LAST) begin
					next_lr.cnt = 7'h00;
					next_lr.st  = SNX_ST_ADDR;
					case ({lr.sh[6:0], I_SI})
						`SNX_OP_FAST_READ: next_lr.kind = SNX_K_FAST;
						`SNX_OP_SEC_WRITE: next_lr.kind = SNX_K_SEC_WR;
						`SNX_OP_SEC_READ:  next_lr.kind = SNX_K_SEC_RD;
						`SNX_OP_FSEC_READ: next_lr.kind = SNX_K_FSEC_RD;
						`SNX_OP_IDENT: begin
							next_lr.kind = SNX_K_IDENT;
							next_lr.st   = SNX_ST_READ;
							next_lr.tx   = {MAKER_CODE, CONT_CODE, PRODUCT_CODE, 32'h0};
						end
						`SNX_OP_UNIQUE: begin
							next_lr.kind = SNX_K_UNIQUE;
							next_lr.st   = SNX_ST_READ;
							next_lr.tx   = UNIQUE_CODE;
						end
						`SNX_OP_SN_READ: begin
							next_lr.kind = SNX_K_SN_RD;
							next_lr.st   = SNX_ST_READ;
							next_lr.tx   = mem.sn_locked ? mem.serial : 64'h0;
						end
						`SNX_OP_SN_WRITE: begin
							next_lr.kind = SNX_K_SN_WR;
							next_lr.st   = SNX_ST_SN_WR;
						end
						`SNX_OP_DEEP_SLEEP: begin
							next_armed = 1'b1;
							next_lr.st = SNX_ST_IGNORE;
						end
						default: next_lr.st = SNX_ST_IGNORE;
					endcase
				end
			end
			SNX_ST_ADDR: begin
				next_lr.addr = {lr.addr[22:0], I_SI};
				next_lr.cnt  = lr.cnt + 7'h01;
				if (lr.cnt == `SNX_ADDR_LAST) begin
					next_lr.cnt = 7'h00;
					case (lr.kind)
						SNX_K_FAST: begin
							next_lr.st     = SNX_ST_DUMMY;
							next_lr.arr_rd = 1'b1;
							next_lr.addr   = 24'({lr.addr[ARRAY_ADDR_W-2:0], I_SI}); // top bits ignored
						end
						SNX_K_FSEC_RD: begin
							next_lr.st   = SNX_ST_DUMMY;
							next_lr.addr = {16'h0000, lr.addr[6:0], I_SI};
						end
						SNX_K_SEC_RD: begin
							// no dummy: first byte is loaded on the last address bit
							next_lr.st         = SNX_ST_READ;
							next_lr.tx[63:56]  = sec_byte(mem, {lr.addr[6:0], I_SI}, 1'b0);
							next_lr.addr       = {16'h0000, lr.addr[6:0], I_SI} + 24'h1;
							next_lr.over       = ({lr.addr[6:0], I_SI} == `SNX_SEC_TOP);
						end
						default: begin
							next_lr.st   = SNX_ST_SEC_WR;
							next_lr.addr = {16'h0000, lr.addr[6:0], I_SI};
						end
					endcase
				end
			end
			SNX_ST_DUMMY: begin
				next_lr.cnt = lr.cnt + 7'h01;
				if (lr.cnt == `SNX_BYTE_LAST) begin
					next_lr.cnt = 7'h00;
					next_lr.st  = SNX_ST_READ;
					if (lr.kind == SNX_K_FAST) begin
						next_lr.tx[63:56] = I_ARR_RDATA;
						next_lr.addr      = 24'(lr.addr[ARRAY_ADDR_W-1:0] + 1'b1);
					end else begin
						next_lr.tx[63:56] = sec_byte(mem, lr.addr[7:0], 1'b0);
						next_lr.over      = (lr.addr[7:0] == `SNX_SEC_TOP);
						next_lr.addr      = lr.addr + 24'h1;
					end
				end
			end
			SNX_ST_READ: begin
				// serial input is disregarded throughout
				case (lr.kind)
					SNX_K_IDENT: begin
						if (lr.cnt != `SNX_ID_LAST) begin
							next_lr.tx  = {lr.tx[62:0], 1'b0};
							next_lr.cnt = lr.cnt + 7'h01;
						end
					end
					SNX_K_UNIQUE, SNX_K_SN_RD: begin
						if (lr.cnt != `SNX_CODE_LAST) begin
							next_lr.tx  = {lr.tx[62:0], 1'b0};
							next_lr.cnt = lr.cnt + 7'h01;
						end
					end
					default: begin
						next_lr.cnt = {4'h0, lr.cnt[2:0] + 3'h1};
						next_lr.tx  = {lr.tx[62:0], 1'b0};
						if (lr.cnt[2:0] == 3'h7) begin
							if (lr.kind == SNX_K_FAST) begin
								// address wraps at the array top
								next_lr.tx[63:56] = I_ARR_RDATA;
								next_lr.addr      = 24'(lr.addr[ARRAY_ADDR_W-1:0] + 1'b1);
							end else begin
								// past the sector top: zeros, no wrap
								next_lr.tx[63:56] = sec_byte(mem, lr.addr[7:0], lr.over);
								next_lr.over      = lr.over | (lr.addr[7:0] == `SNX_SEC_TOP);
								next_lr.addr      = lr.addr + 24'h1;
							end
						end
					end
				endcase
			end
			SNX_ST_SN_WR: begin
				next_lr.tx  = {lr.tx[62:0], I_SI};
				next_lr.cnt = lr.cnt + 7'h01;
				if (lr.cnt == `SNX_CODE_LAST) begin
					next_lr.st = SNX_ST_IGNORE;
					wr_sn      = latch_s & ~mem.sn_locked;
				end
			end
			SNX_ST_SEC_WR: begin
				next_lr.sh  = {lr.sh[6:0], I_SI};
				next_lr.cnt = {4'h0, lr.cnt[2:0] + 3'h1};
				if (lr.cnt[2:0] == 3'h7) begin
					wr_sec = latch_s & ~lr.over;
					if (!lr.over) begin
						next_lr.over = (lr.addr[7:0] == `SNX_SEC_TOP);
						next_lr.addr = lr.addr + 24'h1;
					end
				end
			end
			SNX_ST_IGNORE: begin
				next_lr = lr;
			end
			default: next_lr.st = SNX_ST_IGNORE;
		endcase
	end

	// frame state, cleared whenever select is high
	always_ff @(posedge I_SCK or negedge link_rst_b) begin
		if (!link_rst_b) begin
			lr <= '{st: SNX_ST_CMD, kind: SNX_K_FAST, default: '0};
		end else begin
			lr <= next_lr;
		end
	end

	// sleep arm lives one edge only, so any later edge cancels it
	always_ff @(posedge I_SCK or negedge arm_rst_b) begin
		if (!arm_rst_b) begin
			armed <= 1'b0;
		end else begin
			armed <= next_armed;
		end
	end

	// output shifts on the falling edge, floats unless reading
	always_ff @(negedge I_SCK or negedge link_rst_b) begin
		if (!link_rst_b) begin
			so_q    <= 1'b0;
			so_oe_q <= 1'b0;
		end else begin
			so_q    <= lr.tx[63];
			so_oe_q <= (lr.st == SNX_ST_READ);
		end
	end

	assign O_SO       = so_q;
	assign O_SO_OE    = so_oe_q;
	assign O_ARR_ADDR = lr.addr[ARRAY_ADDR_W-1:0];
	assign O_ARR_RD   = lr.arr_rd;

	////////////////////////////////////////////////////////////////////////////
	// sector and serial-number storage, kept across frames

	always_comb begin
		next_mem = mem;
		if (wr_sec) begin
			next_mem.sector[wr_idx] = wr_byte;
		end
		if (wr_sn) begin
			next_mem.serial    = {lr.tx[62:0], I_SI};
			next_mem.sn_locked = 1'b1;
		end
	end

	always_ff @(posedge I_SCK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			mem <= '0;
		end else begin
			mem <= next_mem;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// system side: sleep, wake, write latch and protection

	always_comb begin
		next_sr         = sr;
		next_sr.cs_prev = sel_s;
		case (sr.st)
			SNX_SY_RUN: begin
				if (!sel_s && sr.cs_prev && armed_s) begin
					next_sr.st     = SNX_SY_SLEEP;
					next_sr.asleep = 1'b1;
				end
			end
			SNX_SY_SLEEP: begin
				if (sel_s && !sr.cs_prev) begin
					next_sr.st    = SNX_SY_WAKE;
					next_sr.timer = 10'h000;
				end
			end
			SNX_SY_WAKE: begin
				next_sr.timer = sr.timer + 10'h001;
				// sync flops and edge register already used three cycles
				if (sr.timer == 10'(WAKE_CYCLES - 4)) begin
					next_sr.st     = SNX_SY_RUN;
					next_sr.asleep = 1'b0;
				end
			end
			default: next_sr.st = SNX_SY_RUN;
		endcase
		// latch commands count only while awake
		if (!sr.asleep && I_SET_LATCH) begin
			next_sr.latch = 1'b1;
		end
		if (!sr.asleep && I_CLEAR_LATCH) begin
			next_sr.latch = 1'b0;
		end
		if (sr.st == SNX_SY_WAKE && next_sr.st == SNX_SY_RUN) begin
			next_sr.latch = 1'b0;
		end
		next_sr.status_ok = sr.latch & ~(I_STATUS_LOCK_ENABLE & ~wp_s);
		next_sr.array_ok  = sr.latch & ~prot_hit(I_PROTECT_SIZE_HI, I_PROTECT_SIZE_LO,
		                                         I_CHK_ADDR);
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sr <= '{st: SNX_SY_RUN, default: '0};
		end else begin
			sr <= next_sr;
		end
	end

	assign O_WRITE_LATCH  = sr.latch;
	assign O_STATUS_WR_OK = sr.status_ok;
	assign O_ARRAY_WR_OK  = sr.array_ok;
	assign O_DEEP_SLEEP   = sr.asleep;

endmodule // snx_top

// ### dv/snx_assertions.sv
// checker for the extended command block outputs
`timescale 1ns/1ps
module snx_assertions #(
	parameter int ARRAY_ADDR_W = 18
) (
	input wire logic                    I_SYS_CLK,            // system clock
	input wire logic                    I_RST_B,              // reset, active low
	input wire logic                    I_SCK,                // serial clock
	input wire logic                    I_CS_B,               // select, active low
	input wire logic                    I_WP_B,               // guard pin
	input wire logic                    O_SO,                 // serial out
	input wire logic                    O_SO_OE,              // serial out enable
	input wire logic                    O_ARR_RD,             // array read active
	input wire logic                    I_SET_LATCH,          // set pulse
	input wire logic                    I_CLEAR_LATCH,        // clear pulse
	input wire logic                    I_PROTECT_SIZE_LO,    // protect low bit
	input wire logic                    I_PROTECT_SIZE_HI,    // protect high bit
	input wire logic                    I_STATUS_LOCK_ENABLE, // status lock
	input wire logic [ARRAY_ADDR_W-1:0] I_CHK_ADDR,           // checked address
	input wire logic                    O_WRITE_LATCH,        // latch
	input wire logic                    O_STATUS_WR_OK,       // status write ok
	input wire logic                    O_ARRAY_WR_OK,        // array write ok
	input wire logic                    O_DEEP_SLEEP          // asleep or waking
);
	int wake_cnt; // cycles since the waking select fall

	// count wake recovery cycles
	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			wake_cnt <= 0;
		else if (!O_DEEP_SLEEP)
			wake_cnt <= 0;
		else if (!I_CS_B || wake_cnt != 0)
			wake_cnt <= wake_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_B);

	a_so_fall_edge: assert property (!$stable(O_SO) && !I_CS_B |-> !I_SCK)
		else $error("serial out moved while the clock was high");
	a_desel_idle: assert property (I_CS_B |-> !O_SO_OE && !O_ARR_RD)
		else $error("output active while deselected");
	a_sleep_quiet: assert property (O_DEEP_SLEEP |-> !O_SO_OE)
		else $error("serial out driven while asleep");
	a_no_latch_block: assert property (!O_WRITE_LATCH && !I_SET_LATCH |=> !O_STATUS_WR_OK && !O_ARRAY_WR_OK)
		else $error("write allowed with latch clear");
	a_prot_all: assert property (I_PROTECT_SIZE_HI && I_PROTECT_SIZE_LO |=> !O_ARRAY_WR_OK)
		else $error("array write allowed with full protection");
	a_prot_quarter: assert property (!I_PROTECT_SIZE_HI && I_PROTECT_SIZE_LO
		&& I_CHK_ADDR[ARRAY_ADDR_W-1 -: 2] == 2'b11 |=> !O_ARRAY_WR_OK)
		else $error("upper quarter write allowed");
	a_unprot_open: assert property (O_WRITE_LATCH && !I_CLEAR_LATCH && !I_PROTECT_SIZE_HI && !I_PROTECT_SIZE_LO
		|=> O_ARRAY_WR_OK || !O_WRITE_LATCH)
		else $error("unprotected write refused");
	a_status_open: assert property (O_WRITE_LATCH && !I_CLEAR_LATCH && !I_STATUS_LOCK_ENABLE
		|=> O_STATUS_WR_OK || !O_WRITE_LATCH)
		else $error("status write refused without lock");
	a_status_locked: assert property ((I_STATUS_LOCK_ENABLE && !I_WP_B) [*4] |=> !O_STATUS_WR_OK)
		else $error("status write allowed while locked");
	a_wake_bound: assert property (wake_cnt <= 1000)
		else $error("wake recovery too long");
	a_wake_latch: assert property ($fell(O_DEEP_SLEEP) |-> ##[0:1] !O_WRITE_LATCH)
		else $error("latch kept after wake");

	c_sleep: cover property ($rose(O_DEEP_SLEEP));
	c_read: cover property ($rose(O_SO_OE));
	c_wr_ok: cover property ($rose(O_ARRAY_WR_OK));
endmodule // snx_assertions

bind snx_top snx_assertions #(.ARRAY_ADDR_W(ARRAY_ADDR_W)) u_chk (
	.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_SCK(I_SCK), .I_CS_B(I_CS_B), .I_WP_B(I_WP_B),
	.O_SO(O_SO), .O_SO_OE(O_SO_OE), .O_ARR_RD(O_ARR_RD), .I_SET_LATCH(I_SET_LATCH),
	.I_CLEAR_LATCH(I_CLEAR_LATCH), .I_PROTECT_SIZE_LO(I_PROTECT_SIZE_LO),
	.I_PROTECT_SIZE_HI(I_PROTECT_SIZE_HI), .I_STATUS_LOCK_ENABLE(I_STATUS_LOCK_ENABLE),
	.I_CHK_ADDR(I_CHK_ADDR), .O_WRITE_LATCH(O_WRITE_LATCH), .O_STATUS_WR_OK(O_STATUS_WR_OK),
	.O_ARRAY_WR_OK(O_ARRAY_WR_OK), .O_DEEP_SLEEP(O_DEEP_SLEEP));

// ### dv/snx_host_model.sv
// serial host model driving select, clock and data
`timescale 1ns/1ps
module snx_host_model (
	output logic      o_sck,  // serial clock, idles at cpol: low in mode 0, high in mode 3
	output logic      o_cs_b, // select, active low
	output logic      o_si,   // data to device
	input  wire logic i_so    // data from device
);
	localparam int HALF = 40; // 80 ns link period
	logic [7:0] tx_buf [0:8]; // bytes sent after select falls
	logic [7:0] rx_byte;      // last byte read back
	event       rx_ev;        // fires per byte read back
	logic       cpol = 1'b0;  // clock idle level: 0 mode 0, 1 mode 3

	initial begin
		o_sck = 1'b0;
		o_cs_b = 1'b1;
		o_si = 1'b0;
	end

	// one frame: ntx bytes out, then nrx clocks of reading
	task automatic run(input int ntx, input int nrx);
		logic [7:0] sh;
		o_sck = cpol; // idle level of the chosen mode
		#7 o_cs_b = 1'b0; // mode 0 or 3, clock stands still outside frames
		#HALF;
		if (cpol)
			#HALF o_sck = 1'b0; // mode 3 opens with a falling edge
		for (int i = 0; i < 8 * ntx + nrx; i++) begin
			if (i < 8 * ntx)
				o_si = tx_buf[i / 8][7 - i % 8];
			else
				o_si = ~o_si; // don't-care input keeps toggling
			#HALF o_sck = 1'b1;
			if (i >= 8 * ntx) begin
				sh = {sh[6:0], i_so};
				if ((i - 8 * ntx) % 8 == 7) begin
					rx_byte = sh;
					->rx_ev;
				end
			end
			if (!cpol || i < 8 * ntx + nrx - 1)
				#HALF o_sck = 1'b0; // mode 3 ends with the clock high
		end
		#HALF o_cs_b = 1'b1;
		o_si = ~o_si; // released line shows no stale value
		#200;
	endtask

	// short select pulse wakes the device, then stay high through recovery
	task automatic wake();
		#7 o_cs_b = 1'b0;
		#100 o_cs_b = 1'b1;
	endtask
endmodule // snx_host_model

// ### dv/snx_top_tb_top.sv
// self-checking bench for the extended command block
`timescale 1ns/1ps
module snx_top_tb_top;
	localparam logic [7:0]  MK = 8'h3c;                   // arbitrary value
	localparam logic [7:0]  CC = 8'h7f;                   // arbitrary value
	localparam logic [15:0] PC = 16'hc5a1;                // arbitrary value
	localparam logic [63:0] UC = 64'hf00d_1357_2468_9ace; // arbitrary value
	logic        sys_clk = 1'b0, rst_b = 1'b0, set_l = 1'b0, clr_l = 1'b0, wp_b = 1'b1;
	logic        bp_lo = 1'b0, bp_hi = 1'b0, lock = 1'b0, lm = 1'b0, rd_seen = 1'b0;
	logic [17:0] chk_addr = 18'h0, arr_addr;
	logic        sck, cs_b, si, so, so_oe, so_line, arr_rd, latch, st_ok, ar_ok, dsleep;
	logic [7:0]  arr_rdata, exp_q[$];
	logic [31:0] r;
	logic [63:0] sn, sb;
	int          num_errors = 0, check_count = 0, cycles = 0;
	integer      seed = 32'h8e3f;

	function automatic logic [7:0] arr_byte(input logic [17:0] a);
		return a[7:0] ^ {a[17:12], a[9:8]};
	endfunction
	assign arr_rdata = arr_byte(arr_addr);
	assign so_line = so_oe ? so : sck; // floating line shows a moving pattern

	// note that the array read strobe was raised
	always @(posedge arr_rd)
		rd_seen = 1'b1;

	snx_top #(.MAKER_CODE(MK), .CONT_CODE(CC), .PRODUCT_CODE(PC), .UNIQUE_CODE(UC)) u_dut (
		.I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_SCK(sck), .I_CS_B(cs_b), .I_SI(si), .I_WP_B(wp_b),
		.O_SO(so), .O_SO_OE(so_oe), .O_ARR_ADDR(arr_addr), .O_ARR_RD(arr_rd), .I_ARR_RDATA(arr_rdata),
		.I_SET_LATCH(set_l), .I_CLEAR_LATCH(clr_l), .I_PROTECT_SIZE_LO(bp_lo), .I_PROTECT_SIZE_HI(bp_hi),
		.I_STATUS_LOCK_ENABLE(lock), .I_CHK_ADDR(chk_addr), .O_WRITE_LATCH(latch),
		.O_STATUS_WR_OK(st_ok), .O_ARRAY_WR_OK(ar_ok), .O_DEEP_SLEEP(dsleep));
	snx_host_model u_host (.o_sck(sck), .o_cs_b(cs_b), .o_si(si), .i_so(so_line));

	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: read byte %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s is %b, expected %b", $time, what, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic exp_n(input logic [63:0] v, input int n);
		for (int k = 0; k < n; k++)
			exp_q.push_back(v[63 - 8 * k -: 8]);
	endtask

	// send command and data, read nrx bits, then see every note used
	task automatic frame(input logic [7:0] cmd, input logic [63:0] d, input int ntx, input int nrx);
		u_host.tx_buf[0] = cmd;
		for (int k = 0; k < 8; k++)
			u_host.tx_buf[k + 1] = d[63 - 8 * k -: 8];
		u_host.run(ntx, nrx);
		chk_flag(exp_q.size() == 0, 1'b1, "all reads seen");
		$display("test frame %h done", cmd);
	endtask

	task automatic sn_read(input logic [63:0] v);
		exp_n(v, 8);
		frame(8'hc3, 64'h0, 1, 64);
	endtask

	task automatic pulse(input logic s);
		@(negedge sys_clk);
		set_l = s;
		clr_l = !s;
		@(negedge sys_clk);
		set_l = 1'b0;
		clr_l = 1'b0;
	endtask

	// compare each byte read back with the oldest note
	always @(u_host.rx_ev) begin
		if (exp_q.size() == 0)
			chk_flag(1'b1, 1'b0, "unexpected byte");
		else
			chk_byte(u_host.rx_byte, exp_q.pop_front());
	end

	// cut a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			$display("mismatch at %0t: timeout", $time);
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		exp_n({MK, CC, PC, {8{PC[0]}}, 24'h0}, 5);
		frame(8'h9f, 64'h0, 1, 40);
		exp_n(UC, 8);
		exp_n({{8{UC[0]}}, 56'h0}, 1);
		frame(8'h4c, 64'h0, 1, 72);
		sn = {$random(seed), $random(seed)};
		frame(8'hc2, sn, 9, 0); // refused with latch clear
		sn_read(64'h0);
		pulse(1'b1);
		repeat (3) @(negedge sys_clk);
		frame(8'hc2, sn, 9, 0);
		frame(8'hc2, ~sn, 9, 0);
		u_host.cpol = 1'b1;
		sn_read(sn); // read in mode 3
		u_host.cpol = 1'b0;
		chk_flag(latch, 1'b1, "latch after writes");
		sb = {$random(seed), $random(seed)};
		frame(8'h42, {sb[63:48], 8'hfe, sb[23:8], 8'h5a, 16'h0}, 7, 0);
		exp_n(64'h0, 1);
		frame(8'h4b, 64'h0, 4, 8); // no wrap to address zero
		exp_n({sb[23:8], 48'h0}, 3);
		frame(8'h4b, {sb[47:32], 8'hfe, 40'h0}, 4, 24);
		exp_n({sb[23:8], 48'h0}, 2);
		frame(8'h49, {sb[47:32], 8'hfe, sb[7:0], 32'h0}, 5, 16);
		chk_flag(rd_seen, 1'b0, "array read before fast read");
		exp_n({arr_byte(18'h3fffe), arr_byte(18'h3ffff), arr_byte(18'h0), 40'h0}, 3);
		frame(8'h0b, {sb[31:26], 18'h3fffe, sb[7:0], 32'h0}, 5, 24);
		chk_flag(rd_seen, 1'b1, "array read strobe");
		frame(8'hba, 64'h0, 1, 1);
		repeat (10) @(negedge sys_clk);
		chk_flag(dsleep, 1'b0, "sleep after cancel");
		frame(8'hba, 64'h0, 1, 0);
		repeat (10) @(negedge sys_clk);
		chk_flag(dsleep, 1'b1, "sleep entry");
		u_host.wake();
		repeat (1010) @(negedge sys_clk);
		chk_flag(dsleep, 1'b0, "awake");
		chk_flag(latch, 1'b0, "latch after wake");
		for (int i = 0; i < 32; i++) begin
			r = $random(seed);
			{bp_hi, bp_lo, lock, wp_b} = r[3:0];
			chk_addr = r[21:4];
			if (r[23]) begin
				pulse(r[22]);
				lm = r[22];
			end
			repeat (5) @(negedge sys_clk);
			chk_flag(latch, lm, "latch");
			chk_flag(ar_ok, lm && !({bp_hi, bp_lo} == 2'b11 || ({bp_hi, bp_lo} == 2'b01 && chk_addr[17:16] == 2'b11)
				|| ({bp_hi, bp_lo} == 2'b10 && chk_addr[17])), "array write ok");
			chk_flag(st_ok, lm && !(lock && !wp_b), "status write ok");
		end
		$display("test protection done");
		tally_and_finish();
	end
endmodule // snx_top_tb_top
